//--- include/sar_readout_pkg.sv
// shared constants for the converter readout link
`default_nettype none
package sar_readout_pkg;
  localparam int WORD_BITS = 16;                      // result width
  localparam int CLK_NS = 25;                         // 40 MHz system clock
  localparam int CONV_MIN_NS = 500;                   // conversion_duration min
  localparam int CONV_MAX_NS = 710;                   // conversion_duration max
  localparam int CONV_CYC = (CONV_MIN_NS + CLK_NS - 1) / CLK_NS; // rounds up: 20
  localparam int ACQ_NS = 290;                        // acquisition_interval
  localparam int CYC_NS = 1000;                       // cycle_interval
  localparam int CYC_CYC = (CYC_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNVH_NS = 10;                        // start pulse width
  localparam int CNVH_CYC = (CNVH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCK_HALF_CYC = 4;                    // host shift clock half period
  localparam int FIFO_DEPTH = 32;                     // host result buffer
endpackage : sar_readout_pkg
`default_nettype wire

//--- include/sar_link_if.sv
// pin-level link between converter and host
`default_nettype none
interface sar_link_if;
  logic conversionStart;     // host -> converter
  logic readoutShiftClock;   // host -> converter
  logic chainSerialIn;       // host -> converter
  logic resultSerialOut;     // converter -> host, data
  logic resultOe_b;          // converter output enable, low drives
  wire  resultLine;          // resolved wire, pulled high when released
  assign resultLine = resultOe_b ? 1'b1 : resultSerialOut;
  modport converter (input conversionStart, input readoutShiftClock, input chainSerialIn,
                     output resultSerialOut, output resultOe_b);
  modport host (output conversionStart, output readoutShiftClock, output chainSerialIn,
                input resultLine);
endinterface : sar_link_if
`default_nettype wire

//--- verilog/sar_word_fifo.sv
// flip-flop fifo carrying result words to the host user side
`default_nettype none
module sar_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // write side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // read side
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  logic [WIDTH-1:0] mem [DEPTH];   // storage
  logic [AW:0]      wrPtr;         // extra bit tells full from empty
  logic [AW:0]      rdPtr;
  wire  isEmpty = wrPtr == rdPtr;
  wire  isFull  = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  wire  doWrite = inValid && !isFull;
  wire  doRead  = outReady && !isEmpty;
  assign inReady  = !isFull;
  assign outValid = !isEmpty;
  assign outData  = mem[rdPtr[AW-1:0]];
  // pointers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (doWrite) wrPtr <= wrPtr + 1'b1;
      if (doRead) rdPtr <= rdPtr + 1'b1;
    end
  end
  // storage write, no reset needed for data
  always_ff @(posedge clk) begin
    if (doWrite) mem[wrPtr[AW-1:0]] <= inData;
  end
endmodule : sar_word_fifo
`default_nettype wire

//--- verilog/sar_converter_end.sv
// converter end: conversion timing, mode choice and serial shift-out
`default_nettype none
module sar_converter_end (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // link
  sar_link_if.converter    link,
  // user side: sample value taken at conversion end
  input  wire logic [15:0] sampleValue,
  output logic             converting
);
  typedef enum logic [1:0] {IDLE = 2'b00, CONV = 2'b01, READY = 2'b10} conv_t;
  conv_t state;
  // two-flop synchronisers for all pins
  logic [1:0] cnvSync, sckSync, sdiSync;
  logic cnvPrev, sckPrev;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnvSync <= 2'b00; sckSync <= 2'b00; sdiSync <= 2'b00;
      cnvPrev <= 1'b0; sckPrev <= 1'b0;
    end else begin
      cnvSync <= {cnvSync[0], link.conversionStart};
      sckSync <= {sckSync[0], link.readoutShiftClock};
      sdiSync <= {sdiSync[0], link.chainSerialIn};
      cnvPrev <= cnvSync[1];
      sckPrev <= sckSync[1];
    end
  end
  wire cnv = cnvSync[1];
  wire sck = sckSync[1];
  wire sdi = sdiSync[1];
  wire cnvRise = cnv && !cnvPrev;
  wire sckFall = !sck && sckPrev;
  logic [5:0]  convCnt;
  logic        selectMode;   // 1 = chip-select, 0 = chain
  logic        busyArmed;
  logic [15:0] shiftReg;
  logic [4:0]  bitsLeft;
  logic        outEn;
  wire convDone = (state == CONV) && (convCnt == 6'(sar_readout_pkg::CONV_CYC - 1));
  wire selected = !cnv || !sdi;
  // conversion sequencer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= IDLE; convCnt <= '0; selectMode <= 1'b1; busyArmed <= 1'b0;
    end else begin
      case (state)
        IDLE, READY: if (cnvRise) begin
          state <= CONV; convCnt <= '0;
          selectMode <= sdi;
          busyArmed <= 1'b0;
        end
        CONV: begin
          convCnt <= convCnt + 6'd1;
          if (convDone) begin
            state <= READY;
            busyArmed <= !sdi || !cnv;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end
  // shift register and output enable
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shiftReg <= '0; bitsLeft <= '0; outEn <= 1'b0;
    end else if (convDone) begin
      shiftReg <= sampleValue;
      bitsLeft <= 5'd16;
      outEn <= selectMode ? selected : 1'b1;
    end else if (state == READY) begin
      if (selectMode) begin
        outEn <= selected && bitsLeft != 0;
      end else if (busyArmed && sdi && bitsLeft == 5'd16 && !cnv) begin
        outEn <= 1'b1;
      end
      if (sckFall && bitsLeft != 0) begin
        shiftReg <= {shiftReg[14:0], selectMode ? 1'b0 : sdi};
        bitsLeft <= selectMode ? bitsLeft - 5'd1 : bitsLeft;
      end
    end
  end
  // outputs registered
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link.resultSerialOut <= 1'b0;
      link.resultOe_b <= 1'b1;
      converting <= 1'b0;
    end else begin
      link.resultSerialOut <= (busyArmed && !selectMode && !cnv && bitsLeft == 5'd16) ? sdi : shiftReg[15];
      link.resultOe_b <= !outEn;
      converting <= state == CONV;
    end
  end
endmodule : sar_converter_end
`default_nettype wire

//--- verilog/sar_host_end.sv
// host end: starts conversions, makes shift clock, collects words
`default_nettype none
module sar_host_end (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // link
  sar_link_if.host         link,
  // user request
  input  wire logic        startReq,
  input  wire logic        chainMode,
  // result stream
  output logic [15:0]      wordData,
  output logic             wordValid,
  input  wire logic        wordReady
);
  typedef enum logic [2:0] {H_IDLE = 3'b000, H_PULSE = 3'b001, H_WAIT = 3'b010,
                            H_SHIFT = 3'b011, H_GAP = 3'b100} host_t;
  host_t state;
  logic [1:0]  lineSync;
  logic [5:0]  cnt;
  logic [4:0]  bitCnt;
  logic [2:0]  halfCnt;
  logic [15:0] rxWord;
  logic        pushValid;
  logic        fifoReady;
  logic        cnvOut, sckOut, sdiOut;
  logic        mode;
  // line synchroniser
  always_ff @(posedge clk) begin
    if (!rst_b) lineSync <= 2'b11;
    else lineSync <= {lineSync[0], link.resultLine};
  end
  localparam int WAIT_CYC = (sar_readout_pkg::CONV_MAX_NS + sar_readout_pkg::CLK_NS - 1) / sar_readout_pkg::CLK_NS + 4;
  wire halfDone = halfCnt == 3'(sar_readout_pkg::SCK_HALF_CYC - 1);
  // sequencer; clock halves of four cycles keep well over
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= H_IDLE; cnt <= '0; bitCnt <= '0; halfCnt <= '0; rxWord <= '0;
      pushValid <= 1'b0; cnvOut <= 1'b0; sckOut <= 1'b0; sdiOut <= 1'b1; mode <= 1'b0;
    end else begin
      pushValid <= 1'b0;
      case (state)
        H_IDLE: if (startReq && fifoReady) begin
          mode <= chainMode;
          sdiOut <= !chainMode;
          cnvOut <= 1'b1; sckOut <= 1'b0;
          cnt <= '0; state <= H_PULSE;
        end
        H_PULSE: begin
          cnt <= cnt + 6'd1;
          if (cnt == 6'(sar_readout_pkg::CNVH_CYC + 3)) begin
            cnvOut <= mode;
            state <= H_WAIT;
          end
        end
        H_WAIT: begin
          cnt <= cnt + 6'd1;
          if (cnt == 6'(WAIT_CYC + sar_readout_pkg::CNVH_CYC + 4)) begin
            // select mode keeps start low, as dropped at pulse end; chain mode keeps start high while reading
            sdiOut <= 1'b0; cnvOut <= mode;
            bitCnt <= '0; halfCnt <= '0; state <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          halfCnt <= halfDone ? 3'd0 : halfCnt + 3'd1;
          if (halfDone) begin
            if (!sckOut) begin
              sckOut <= 1'b1;
            end else begin
              sckOut <= 1'b0;
              rxWord <= {rxWord[14:0], lineSync[1]};
              bitCnt <= bitCnt + 5'd1;
              if (bitCnt == 5'd15) begin
                pushValid <= 1'b1; sdiOut <= 1'b1; cnvOut <= 1'b0;
                cnt <= '0; state <= H_GAP;
              end
            end
          end
        end
        H_GAP: begin
          cnt <= cnt + 6'd1;
          if (cnt == 6'(sar_readout_pkg::CYC_CYC)) state <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link.conversionStart <= 1'b0; link.readoutShiftClock <= 1'b0; link.chainSerialIn <= 1'b1;
    end else begin
      link.conversionStart <= cnvOut; link.readoutShiftClock <= sckOut; link.chainSerialIn <= sdiOut;
    end
  end
  sar_word_fifo #(.WIDTH(16), .DEPTH(sar_readout_pkg::FIFO_DEPTH)) fifo (
    .clk(clk), .rst_b(rst_b), .inData(rxWord), .inValid(pushValid), .inReady(fifoReady),
    .outData(wordData), .outValid(wordValid), .outReady(wordReady));
endmodule : sar_host_end
`default_nettype wire

//--- test/sar_readout_checker.sv
// assertions watching the converter readout link
`default_nettype none
module sar_readout_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link signals
  input wire logic conversionStart,
  input wire logic readoutShiftClock,
  input wire logic chainSerialIn,
  input wire logic resultSerialOut,
  input wire logic resultOe_b,
  input wire logic resultLine
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       csMode;     // mode latched at start edge
  logic [7:0] sinceStart; // cycles since start rise, saturates
  logic [4:0] fallCnt;    // shift clock falls while driving
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // helper counters; saturated start count lets the first start pass
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      csMode     <= 1'b1;
      sinceStart <= 8'hFF;
    end else if ($rose(conversionStart)) begin
      csMode     <= chainSerialIn;
      sinceStart <= 8'h00;
    end else if (sinceStart != 8'hFF) begin
      sinceStart <= sinceStart + 8'h01;
    end
  end
  // falls counted only while the output is driven
  always_ff @(posedge clk) begin
    if (!rst_b || resultOe_b) fallCnt <= 5'h00;
    else if ($fell(readoutShiftClock)) fallCnt <= fallCnt + 5'h01;
  end
  a_conv_min_time: assert property ($fell(resultOe_b) |-> sinceStart >= 8'(sar_readout_pkg::CONV_CYC))
    else $error("output enabled before conversion end");
  a_enable_cause: assert property ($fell(resultOe_b) |-> (!conversionStart || !chainSerialIn))
    else $error("output enabled without select");
  a_deselect_release: assert property (csMode && !resultOe_b && $rose(conversionStart && chainSerialIn)
    |-> ##[0:6] resultOe_b) else $error("output not released after deselect");
  a_last_bit_release: assert property (csMode && !resultOe_b && $fell(readoutShiftClock) && fallCnt == 5'h0F
    |-> ##[0:6] resultOe_b) else $error("output not released after last bit");
  a_sixteen_bits: assert property (csMode && $rose(resultOe_b) |-> fallCnt == 5'h10)
    else $error("word not sixteen shift clocks");
  a_bit_stable_high: assert property (!resultOe_b && !$past(resultOe_b) && readoutShiftClock
    && $past(readoutShiftClock) |-> $stable(resultSerialOut)) else $error("bit moved while clock high");
  a_clock_high_time: assert property ($rose(readoutShiftClock) |-> readoutShiftClock[*4] ##1 !readoutShiftClock)
    else $error("shift clock high time wrong");
  a_start_width: assert property ($rose(conversionStart) |=> conversionStart)
    else $error("start pulse too short");
  a_clock_steady_start: assert property ($rose(conversionStart) |-> $stable(readoutShiftClock)
    ##1 $stable(readoutShiftClock)) else $error("shift clock moved at start");
  a_start_spacing: assert property ($rose(conversionStart) |-> sinceStart >= 8'(sar_readout_pkg::CYC_CYC))
    else $error("starts too close");
  c_select_start: cover property ($rose(conversionStart) && chainSerialIn);
  c_chain_start: cover property ($rose(conversionStart) && !chainSerialIn);
  c_full_word: cover property ($rose(resultOe_b) && fallCnt == 5'h10);
endmodule : sar_readout_checker
`default_nettype wire

//--- test/sar_adc_serial_readout_tb.sv
// self-checking bench joining converter end and host end
`default_nettype none
module sar_adc_serial_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;             // 40 MHz clock
  logic        rst_b = 1'b0;           // sync reset, low active
  logic [15:0] sampleValue = 16'h0000; // value converted
  logic        startReq = 1'b0;        // conversion request
  logic        chainMode = 1'b0;       // mode choice
  logic        wordReady = 1'b1;       // user accepts words
  logic [15:0] wordData;
  logic        wordValid;
  logic        converting;
  int          bad_count = 0;
  int          checks = 0;
  logic [15:0] expq[$];                // expected words, oldest first
  sar_link_if link ();
  always #12.5 clk = ~clk;
  sar_converter_end sar_converter_end_i (.clk(clk), .rst_b(rst_b), .link(link), .sampleValue(sampleValue),
    .converting(converting));
  sar_host_end sar_host_end_i (.clk(clk), .rst_b(rst_b), .link(link), .startReq(startReq), .chainMode(chainMode),
    .wordData(wordData), .wordValid(wordValid), .wordReady(wordReady));
  sar_readout_checker sar_readout_checker_i (.clk(clk), .rst_b(rst_b), .conversionStart(link.conversionStart),
    .readoutShiftClock(link.readoutShiftClock), .chainSerialIn(link.chainSerialIn),
    .resultSerialOut(link.resultSerialOut), .resultOe_b(link.resultOe_b), .resultLine(link.resultLine));
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // a bounded wait that ran out
  task automatic hang;
    check(16'hDEAD, 16'h0000);
    stop_test;
  endtask : hang
  // words leaving the stream, popped at the accepting edge
  always @(posedge clk) begin
    if (wordValid === 1'b1 && wordReady === 1'b1 && expq.size() > 0) check(wordData, expq.pop_front());
  end
  // one conversion: request, mode at start edge, conversion time
  task automatic xfer(input logic [15:0] v, input logic m);
    int n;
    @(negedge clk);
    sampleValue = v;
    chainMode = m;
    startReq = 1'b1;
    for (n = 0; n < 4000 && link.conversionStart !== 1'b1; n++) @(negedge clk);
    if (link.conversionStart !== 1'b1) hang();
    check(16'(link.chainSerialIn), 16'(!m));
    startReq = 1'b0;
    for (n = 0; n < 10 && converting !== 1'b1; n++) @(negedge clk);
    for (; n < 60 && converting !== 1'b0; n++) @(negedge clk);
    if (n >= 60) hang();
    check(16'(n >= 20 && n <= 29), 16'h0001);
    if (!m) expq.push_back(v);
  endtask : xfer
  // let the stream empty under a bound
  task automatic drain;
    int n;
    wordReady = 1'b1;
    for (n = 0; n < 4000 && expq.size() > 0; n++) @(negedge clk);
    if (expq.size() > 0) hang();
  endtask : drain
  // main sequence
  initial begin
    int i;
    logic [15:0] corner[4];
    corner = '{16'h8000, 16'h7FFF, 16'h0000, 16'hFFFF};
    void'($urandom(6337));
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    foreach (corner[k]) xfer(corner[k], 1'b0);
    for (i = 0; i < 8; i++) xfer(16'($urandom), 1'b0);
    drain();
    $display("test single words done");
    // fill the buffer with the user stalled, then one more request
    wordReady = 1'b0;
    for (i = 0; i < 32; i++) xfer(16'($urandom), 1'b0);
    repeat (400) @(negedge clk);
    check(16'(wordValid), 16'h0001);
    startReq = 1'b1;
    for (i = 0; i < 300 && link.conversionStart !== 1'b1; i++) @(negedge clk);
    check(16'(link.conversionStart), 16'h0000);
    startReq = 1'b0;
    drain();
    $display("test full buffer done");
    // chain mode start; its data is not compared
    xfer(16'($urandom), 1'b1);
    repeat (400) @(negedge clk);
    $display("test chain start done");
    stop_test();
  end
endmodule : sar_adc_serial_readout_tb
`default_nettype wire
